// ### hw/pcf_config_rx.sv
// pulse-count configuration receiver for a flash led driver
`timescale 1ns/1ps
`include "pcf_regs.svh"
module pcf_config_rx #(
  parameter int unsigned LATCH_CYCLES = `PCF_LATCH_CYCLES,
  parameter int unsigned OFF_CYCLES   = `PCF_OFF_CYCLES
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // pins
  input  wire logic             ctrl_line,
  input  wire logic             flash_trigger_input,
  input  wire logic             flash_inhibit_input,
  // settings and drive state
  output pcf_pkg::pcf_cfg_t     cfg_ff,
  output logic                  enabled_ff,
  output pcf_pkg::pcf_led_t     led_mode_ff,
  output logic [3:0]            drive_level_ff,
  output logic [3:0]            drive_ratio_ff
);
  // refuse timeouts that the line timer cannot count
  if (LATCH_CYCLES < 2 || OFF_CYCLES < 2 ||
      LATCH_CYCLES > 32'h00FF_FFFF || OFF_CYCLES > 32'h00FF_FFFF) begin : g_bad_timeouts
    $error("pcf_config_rx: timeouts out of range");
  end
  // -------------------------------------------------------------
  // line timing
  // -------------------------------------------------------------
  logic       rise_pulse;    // rising edge on the line
  logic       latch_pulse;   // high timeout elapsed
  logic [4:0] latch_count;   // edges in the finished burst
  logic       off_pulse;     // low timeout elapsed

  pcf_line_timer #(
    .LATCH_CYCLES (LATCH_CYCLES),
    .OFF_CYCLES   (OFF_CYCLES)
  ) u_timer (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .ctrl_line      (ctrl_line),
    .rise_pulse_ff  (rise_pulse),
    .latch_pulse_ff (latch_pulse),
    .latch_count_ff (latch_count),
    .off_pulse_ff   (off_pulse)
  );

  // -------------------------------------------------------------
  // pin synchronisers for trigger and inhibit
  // -------------------------------------------------------------
  logic [1:0] trig_sync_ff;   // [0] read only by [1]
  logic [1:0] inh_sync_ff;    // [0] read only by [1]
  logic       trig_prev_ff;   // for trigger rising edge
  logic       trig;
  logic       inh;
  assign trig = trig_sync_ff[1];
  assign inh  = inh_sync_ff[1];

  // two-flop capture of both asynchronous pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_sync_ff <= 2'b00;
      inh_sync_ff  <= 2'b00;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[0], flash_trigger_input};
      inh_sync_ff  <= {inh_sync_ff[0], flash_inhibit_input};
      trig_prev_ff <= trig;
    end
  end

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  // true when a latched count is a usable address
  function automatic logic is_addr(input logic [4:0] cnt);
    is_addr = (cnt >= `PCF_ADDR_BASE) && (cnt <= `PCF_ADDR_MAX)
              && (cnt != (`PCF_ADDR_BASE + 5'h01));   // unused address dropped
  endfunction : is_addr

  // data code equals edge count, 16 edges fit as code 16 = 4'h0 plus wrap
  function automatic logic [3:0] to_code(input logic [4:0] cnt);
    to_code = cnt[3:0];
  endfunction : to_code

  // -------------------------------------------------------------
  // enable state, selected address and written flag
  // -------------------------------------------------------------
  logic [1:0] addr_ff;      // selected register
  logic       written_ff;   // any data write since enable
  logic       flashed_ff;   // a flash has happened since enable
  logic       level_set_ff; // torch level holds a real code

  // enable follows the first edge, ends with shutdown
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enabled_ff <= 1'b0;
      addr_ff    <= `PCF_ADDR_TORCH_LEVEL;
    end else if (off_pulse) begin
      enabled_ff <= 1'b0;
      addr_ff    <= `PCF_ADDR_TORCH_LEVEL;
    end else begin
      if (rise_pulse && !enabled_ff) begin
        enabled_ff <= 1'b1;
        addr_ff    <= `PCF_ADDR_TORCH_LEVEL;
      end
      if (latch_pulse && is_addr(latch_count))
        addr_ff <= 2'(latch_count - `PCF_ADDR_BASE);
      // out of range counts leave the address alone
    end
  end

  // -------------------------------------------------------------
  // setting registers
  // -------------------------------------------------------------
  logic data_ok;
  logic trig_rise;
  assign data_ok   = latch_pulse && latch_count >= `PCF_DATA_MIN && latch_count <= `PCF_DATA_MAX;
  assign trig_rise = trig && !trig_prev_ff;

  // codes are stored as received, 16 kept as 4'h0 which decodes as step 16
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_ff     <= '{`PCF_RST_VALUE, `PCF_RST_VALUE, `PCF_RST_VALUE};
      written_ff <= 1'b0;
    end else if (off_pulse) begin
      cfg_ff     <= '{`PCF_RST_VALUE, `PCF_RST_VALUE, `PCF_RST_VALUE};
      written_ff <= 1'b0;
    end else if (data_ok) begin
      written_ff <= 1'b1;
      unique case (addr_ff)
        `PCF_ADDR_TORCH_LEVEL: cfg_ff.torch_current       <= to_code(latch_count);
        `PCF_ADDR_OUT_ENABLE:  cfg_ff.movie_output_enable <= to_code(latch_count);
        `PCF_ADDR_PEAK_RATIO:  cfg_ff.flash_peak_ratio    <= to_code(latch_count);
        `PCF_ADDR_UNUSED:      written_ff <= written_ff;
      endcase
    end else if (enabled_ff && trig_rise && !written_ff) begin
      cfg_ff <= '{`PCF_DEF_TORCH_LEVEL, `PCF_DEF_OUT_ENABLE, `PCF_DEF_PEAK_RATIO};
    end
  end

  // -------------------------------------------------------------
  // flash history: torch is blocked after a flash
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flashed_ff <= 1'b0;
    end else if (off_pulse) begin
      flashed_ff <= 1'b0;
    end else if (enabled_ff && trig) begin
      // level, not edge, so a trigger already high at enable still counts
      flashed_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // torch level validity
  // -------------------------------------------------------------
  // code 16 is kept as 4'h0, the same as a cleared register, so
  // a separate flag says whether the level holds a real code
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level_set_ff <= 1'b0;
    end else if (off_pulse) begin
      level_set_ff <= 1'b0;
    end else if (data_ok && addr_ff == `PCF_ADDR_TORCH_LEVEL) begin
      level_set_ff <= 1'b1;
    end else if (enabled_ff && trig_rise && !written_ff) begin
      level_set_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // led drive selection
  // -------------------------------------------------------------
  // level codes index a 16-step log table in the analog sink;
  // the torch full scale is flash full scale over seven there
  logic torch_on;
  assign torch_on = (cfg_ff.movie_output_enable >= `PCF_OE_ON_MIN);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      led_mode_ff    <= pcf_pkg::PCF_LED_OFF;
      drive_level_ff <= `PCF_RST_VALUE;
      drive_ratio_ff <= `PCF_RST_VALUE;
    end else if (enabled_ff && trig && inh) begin
      led_mode_ff    <= pcf_pkg::PCF_LED_INHIB;
      drive_level_ff <= `PCF_DEF_TORCH_LEVEL;
      drive_ratio_ff <= cfg_ff.flash_peak_ratio;
    end else if (enabled_ff && trig) begin
      led_mode_ff    <= pcf_pkg::PCF_LED_FLASH;
      drive_level_ff <= cfg_ff.torch_current;
      drive_ratio_ff <= cfg_ff.flash_peak_ratio;
    end else if (enabled_ff && !flashed_ff && torch_on && level_set_ff) begin
      // torch only while no flash has happened since enable
      led_mode_ff    <= pcf_pkg::PCF_LED_TORCH;
      drive_level_ff <= cfg_ff.torch_current;
      drive_ratio_ff <= cfg_ff.flash_peak_ratio;
    end else begin
      // off: disabled, torch blocked, disabled by code, or no level yet
      led_mode_ff    <= pcf_pkg::PCF_LED_OFF;
      drive_level_ff <= `PCF_RST_VALUE;
      drive_ratio_ff <= `PCF_RST_VALUE;
    end
  end
endmodule : pcf_config_rx

// ### hw/pcf_regs.svh
// constants for the pulse-count flash configuration receiver
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
// -------------------------------------------------------------
// register addresses
// -------------------------------------------------------------
`define PCF_ADDR_TORCH_LEVEL   2'h0
`define PCF_ADDR_UNUSED        2'h1
`define PCF_ADDR_OUT_ENABLE    2'h2
`define PCF_ADDR_PEAK_RATIO    2'h3
// -------------------------------------------------------------
// edge count windows
// -------------------------------------------------------------
`define PCF_DATA_MIN           5'h01
`define PCF_DATA_MAX           5'h10
`define PCF_ADDR_BASE          5'h11
`define PCF_ADDR_MAX           5'h14
// -------------------------------------------------------------
// defaults, applied on a trigger before any write, plus reset value and torch-on threshold
// -------------------------------------------------------------
`define PCF_DEF_TORCH_LEVEL    4'h1
`define PCF_DEF_OUT_ENABLE     4'h4
`define PCF_DEF_PEAK_RATIO     4'h1
`define PCF_RST_VALUE          4'h0
`define PCF_OE_ON_MIN          4'h3
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define PCF_CLK_PERIOD_NS      10
`define PCF_LATCH_TIMEOUT_US   500
`define PCF_OFF_TIMEOUT_US     500
`define PCF_LATCH_CYCLES       ((`PCF_LATCH_TIMEOUT_US * 1000) / `PCF_CLK_PERIOD_NS)
`define PCF_OFF_CYCLES         ((`PCF_OFF_TIMEOUT_US * 1000) / `PCF_CLK_PERIOD_NS)
`endif

// ### hw/pcf_pkg.sv
// types shared by the configuration receiver
package pcf_pkg;
  // -------------------------------------------------------------
  // settings bundle
  // -------------------------------------------------------------
  typedef struct packed {
    logic [3:0] torch_current;        // movie level code
    logic [3:0] movie_output_enable;  // output enable code
    logic [3:0] flash_peak_ratio;     // peak ratio code
  } pcf_cfg_t;

  // led drive mode
  typedef enum logic [1:0] {
    PCF_LED_OFF   = 2'b00,
    PCF_LED_TORCH = 2'b01,
    PCF_LED_FLASH = 2'b10,
    PCF_LED_INHIB = 2'b11
  } pcf_led_t;
endpackage : pcf_pkg

// ### hw/pcf_line_timer.sv
// control line synchroniser, edge counter and timeout detector
`timescale 1ns/1ps
`include "pcf_regs.svh"
module pcf_line_timer #(
  parameter int unsigned LATCH_CYCLES = `PCF_LATCH_CYCLES,
  parameter int unsigned OFF_CYCLES   = `PCF_OFF_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // line pin
  input  wire logic       ctrl_line,
  // results
  output logic            rise_pulse_ff,    // one cycle per rising edge
  output logic            latch_pulse_ff,   // one cycle when high timeout ends
  output logic [4:0]      latch_count_ff,   // count valid with latch pulse
  output logic            off_pulse_ff      // one cycle when low timeout ends
);
  // refuse timeouts that the 24-bit timer cannot count
  if (LATCH_CYCLES < 2 || OFF_CYCLES < 2 ||
      LATCH_CYCLES > 32'h00FF_FFFF || OFF_CYCLES > 32'h00FF_FFFF) begin : g_bad_timeouts
    $error("pcf_line_timer: timeout counts out of range");
  end
  // -------------------------------------------------------------
  // synchroniser
  // -------------------------------------------------------------
  logic       sync1_ff;     // first stage, read only by sync2
  logic       sync2_ff;     // stable line level
  logic       prev_ff;      // level one cycle ago
  logic [23:0] timer_ff;    // cycles since last edge
  logic [4:0]  count_ff;    // saturating rising-edge count
  logic        done_ff;     // timeout already reported for this level
  logic        edge_now;
  assign edge_now = sync2_ff ^ prev_ff;

  // two-flop capture of the asynchronous pin
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= ctrl_line;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // -------------------------------------------------------------
  // timeout timer, restarted on every edge
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timer_ff <= 24'h00_0000;
      done_ff  <= 1'b1;               // idle low line counts as already off
    end else if (edge_now) begin
      timer_ff <= 24'h00_0000;
      done_ff  <= 1'b0;
    end else if (!done_ff) begin
      timer_ff <= timer_ff + 24'h00_0001;
      if (sync2_ff && timer_ff == 24'(LATCH_CYCLES - 1))
        done_ff <= 1'b1;
      if (!sync2_ff && timer_ff == 24'(OFF_CYCLES - 1))
        done_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // edge counter and event pulses
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_ff       <= 5'h00;
      rise_pulse_ff  <= 1'b0;
      latch_pulse_ff <= 1'b0;
      latch_count_ff <= 5'h00;
      off_pulse_ff   <= 1'b0;
    end else begin
      rise_pulse_ff  <= edge_now && sync2_ff;
      latch_pulse_ff <= 1'b0;
      off_pulse_ff   <= 1'b0;
      // saturate at 31 so very long bursts never wrap into a valid code
      if (edge_now && sync2_ff && count_ff != 5'h1F)
        count_ff <= count_ff + 5'h01;
      if (!edge_now && !done_ff && sync2_ff && timer_ff == 24'(LATCH_CYCLES - 1)) begin
        latch_pulse_ff <= 1'b1;
        latch_count_ff <= count_ff;
        count_ff       <= 5'h00;
      end
      if (!edge_now && !done_ff && !sync2_ff && timer_ff == 24'(OFF_CYCLES - 1)) begin
        off_pulse_ff <= 1'b1;
        count_ff     <= 5'h00;
      end
    end
  end
endmodule : pcf_line_timer

// ### verif/pcf_config_rx_chk.sv
// port checker for the pulse-count configuration receiver
`timescale 1ns/1ps
module pcf_config_rx_chk #(
  parameter int unsigned LATCH_CYCLES = 64,
  parameter int unsigned OFF_CYCLES   = 64
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // pins
  input wire logic              ctrl_line,
  input wire logic              flash_trigger_input,
  input wire logic              flash_inhibit_input,
  // settings and drive state
  input wire pcf_pkg::pcf_cfg_t cfg_ff,
  input wire logic              enabled_ff,
  input wire pcf_pkg::pcf_led_t led_mode_ff,
  input wire logic [3:0]        drive_level_ff,
  input wire logic [3:0]        drive_ratio_ff
);
  logic [15:0] hi_cnt_ff;   // raw cycles the line has been high
  logic [15:0] lo_cnt_ff;   // raw cycles the line has been low
  logic        flashed_ff;  // a flash was seen since enable
  // ----------------------------------------
  // line run lengths, saturating so long idles never wrap
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hi_cnt_ff <= '0;
      lo_cnt_ff <= '0;
    end else begin
      hi_cnt_ff <= !ctrl_line ? '0 : hi_cnt_ff + {15'h0000, hi_cnt_ff != 16'hffff};
      lo_cnt_ff <= ctrl_line ? '0 : lo_cnt_ff + {15'h0000, lo_cnt_ff != 16'hffff};
    end
  end
  // flash memory, forgotten only by shutdown
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flashed_ff <= 1'b0;
    end else begin
      flashed_ff <= enabled_ff && (flashed_ff || led_mode_ff inside {pcf_pkg::PCF_LED_FLASH, pcf_pkg::PCF_LED_INHIB});
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_flash_req;
    $rose(flash_trigger_input) && enabled_ff && !flash_inhibit_input;
  endsequence
  sequence s_flash_up;
    ##[1:6] led_mode_ff == pcf_pkg::PCF_LED_FLASH;
  endsequence
  AST_LATCH_WAIT: assert property (
    $changed(cfg_ff) && enabled_ff && !flash_trigger_input |-> hi_cnt_ff >= LATCH_CYCLES)
    else $error("settings changed before the line was high long enough");
  AST_WAKE_ON_EDGE: assert property ($rose(ctrl_line) |-> ##[1:8] enabled_ff)
    else $error("no enable after a rising edge");
  AST_OFF_LATE: assert property (lo_cnt_ff == OFF_CYCLES + 8 |-> !enabled_ff)
    else $error("no shutdown after a long low");
  AST_OFF_EARLY: assert property ($fell(enabled_ff) && !$past(reset) |-> lo_cnt_ff >= OFF_CYCLES)
    else $error("shutdown before the low timeout");
  AST_OFF_CLEARS: assert property ($fell(enabled_ff) && !$past(reset) |-> cfg_ff == '0)
    else $error("settings not cleared at shutdown");
  AST_TORCH_GATE: assert property (
    led_mode_ff == pcf_pkg::PCF_LED_TORCH && $stable(cfg_ff) |->
      cfg_ff.movie_output_enable inside {4'h3, 4'h4} && drive_level_ff == cfg_ff.torch_current)
    else $error("torch drive with output disabled or wrong level");
  AST_FLASH_ON: assert property (s_flash_req |-> s_flash_up)
    else $error("flash did not start on trigger");
  AST_RATIO: assert property (
    led_mode_ff == pcf_pkg::PCF_LED_FLASH && $stable(cfg_ff) |-> drive_ratio_ff == cfg_ff.flash_peak_ratio)
    else $error("flash ratio differs from setting");
  AST_NO_RETURN: assert property (flashed_ff |-> led_mode_ff != pcf_pkg::PCF_LED_TORCH)
    else $error("torch resumed after a flash");
  AST_INHIB_LEVEL: assert property (led_mode_ff == pcf_pkg::PCF_LED_INHIB |-> drive_level_ff == 4'h1)
    else $error("inhibit level is not the default");
endmodule : pcf_config_rx_chk

// ### verif/pcf_host_model.sv
// host model driving the single control line
`timescale 1ns/1ps
module pcf_host_model #(
  parameter int unsigned LATCH_CYCLES = 64,
  parameter int unsigned OFF_CYCLES   = 64
) (
  // clock and line
  input wire logic ref_clk,
  output logic     ctrl_line
);
  initial ctrl_line = 1'b0;
  // moves always land just after a clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_clk
  // n rising edges, low time varied, ends high
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      ctrl_line = 1'b0;
      wait_clk(3 + i % 3);
      ctrl_line = 1'b1;
      wait_clk(4);
    end
  endtask : pulses
  // pause past the latch timeout closes a burst
  task automatic hold();
    ctrl_line = 1'b1;
    wait_clk(LATCH_CYCLES + 12);
  endtask : hold
  // low past the off timeout
  task automatic off();
    ctrl_line = 1'b0;
    wait_clk(OFF_CYCLES + 12);
  endtask : off
endmodule : pcf_host_model

// ### verif/test_pcf_config_rx.sv
// self-checking bench for the configuration receiver
`timescale 1ns/1ps
module test_pcf_config_rx;
  localparam int unsigned LAT = 64;  // short timeouts keep the run brief
  localparam int unsigned OFF = 64;
  logic              ref_clk;
  logic              reset;
  logic              trg;
  logic              inh;
  wire logic         ctrl_line;
  pcf_pkg::pcf_cfg_t cfg;
  logic              en;
  pcf_pkg::pcf_led_t mode;
  logic [3:0]        lvl;
  logic [3:0]        rat;
  int                mismatches;
  int                tests_run;
  pcf_config_rx #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcf_config_rx_i (.ref_clk(ref_clk), .reset(reset),
    .ctrl_line(ctrl_line), .flash_trigger_input(trg), .flash_inhibit_input(inh), .cfg_ff(cfg),
    .enabled_ff(en), .led_mode_ff(mode), .drive_level_ff(lvl), .drive_ratio_ff(rat));
  pcf_host_model #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcf_host_model_i (.ref_clk(ref_clk),
    .ctrl_line(ctrl_line));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic tx(input int n);
    pcf_host_model_i.pulses(n);
    pcf_host_model_i.hold();
  endtask : tx
  task automatic wr(input int a, input int d);
    tx(17 + a);
    tx(d);
  endtask : wr
  task automatic chk_cfg(input string nm, input pcf_pkg::pcf_cfg_t ex, input pcf_pkg::pcf_cfg_t got);
    tests_run++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_cfg
  task automatic chk_sig(input string nm, input logic [3:0] ex, input logic [3:0] got);
    tests_run++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_sig
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs();
    wr(2, 3);
    chk_sig("oe", 4'h3, cfg.movie_output_enable);
    chk_sig("en", 4'h1, {3'b000, en});
    wr(0, 5);
    chk_sig("lvl", 4'h5, lvl);
    chk_sig("mode", 4'h1, {2'b00, mode});
    wr(2, 2);
    chk_sig("mode", 4'h0, {2'b00, mode});
    tx(4);
    chk_sig("mode", 4'h1, {2'b00, mode});
    wr(3, 4);
    wr(0, 16);
    chk_cfg("cfg", pcf_pkg::pcf_cfg_t'(12'h044), cfg);
    chk_sig("mode", 4'h1, {2'b00, mode});
    chk_sig("lvl", 4'h0, lvl);
    tx(18);
    tx(3);
    chk_cfg("cfg", pcf_pkg::pcf_cfg_t'(12'h344), cfg);
    tx(21);
    tx(7);
    chk_cfg("cfg", pcf_pkg::pcf_cfg_t'(12'h744), cfg);
    pcf_host_model_i.off();
    chk_cfg("cfg", pcf_pkg::pcf_cfg_t'(12'h000), cfg);
    chk_sig("en", 4'h0, {3'b000, en});
  endtask : s_regs
  // trigger before any write, data burst still open
  task automatic s_defaults();
    pcf_host_model_i.pulses(3);
    trg = 1'b1;
    step(8);
    chk_cfg("dflt", pcf_pkg::pcf_cfg_t'(12'h141), cfg);
    chk_sig("mode", 4'h2, {2'b00, mode});
    pcf_host_model_i.hold();
    trg = 1'b0;
    step(8);
    chk_cfg("adr0", pcf_pkg::pcf_cfg_t'(12'h341), cfg);
    chk_sig("mode", 4'h0, {2'b00, mode});
    pcf_host_model_i.off();
  endtask : s_defaults
  // flash with output disabled, then inhibit
  task automatic s_flash();
    wr(2, 1);
    wr(3, 2);
    wr(0, 9);
    chk_sig("mode", 4'h0, {2'b00, mode});
    trg = 1'b1;
    step(8);
    chk_sig("mode", 4'h2, {2'b00, mode});
    chk_sig("rat", 4'h2, rat);
    inh = 1'b1;
    step(8);
    chk_sig("mode", 4'h3, {2'b00, mode});
    chk_sig("lvl", 4'h1, lvl);
    inh = 1'b0;
    step(8);
    chk_sig("mode", 4'h2, {2'b00, mode});
    trg = 1'b0;
    wr(2, 3);
    chk_sig("mode", 4'h0, {2'b00, mode});
  endtask : s_flash
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    trg = 1'b0;
    inh = 1'b0;
    mismatches = 0;
    tests_run = 0;
    step(12);
    reset = 1'b0;
    s_regs();
    s_defaults();
    s_flash();
    close_out();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : test_pcf_config_rx
bind pcf_config_rx pcf_config_rx_chk #(.LATCH_CYCLES(LATCH_CYCLES), .OFF_CYCLES(OFF_CYCLES)) pcf_config_rx_chk_i (
  .ref_clk(ref_clk), .reset(reset), .ctrl_line(ctrl_line), .flash_trigger_input(flash_trigger_input),
  .flash_inhibit_input(flash_inhibit_input), .cfg_ff(cfg_ff), .enabled_ff(enabled_ff),
  .led_mode_ff(led_mode_ff), .drive_level_ff(drive_level_ff), .drive_ratio_ff(drive_ratio_ff));
